// ### rtl/timer_capture_mode_control.sv
// Timer channel: control and mode registers, clock select, capture and match clear
//
// Notes on behaviour
// - Control bit 5 makes the channel start only with its group start pulse.
// - Control bit 3 keeps the channel counting in idle, otherwise idle halts it.
// - Writing 0 to mode bit 5 captures the counter into capture register 0; it reads as 1.
// - Capture timing 00 disables hardware capture.
// - Capture timing 01 loads register 0 on input 0 rising and register 1 on input 1 rising.
// - Capture timing 10 loads register 0 on input 0 rising and register 1 on its falling.
// - Capture timing 11 loads register 0 on match output rising and register 1 on falling.
// - The match output used for capture comes from the group leader channel input.
// - Mode bit 2 clears the counter to zero when it matches compare register 1.
// - Mode bits 1-0 pick pin input 0 or prescale taps 1, 4 and 16 as count source.
// - The channel holds a 16-bit up-counter, compare register and two capture registers.
// - With the enable bit 0 other registers neither update nor answer, but keep values.
`timescale 1ns/1ps

module timer_capture_mode_control
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Pins and neighbours
  input  wire logic        capture_input_0,
  input  wire logic        capture_input_1,
  input  wire logic        group_leader_match_out,
  input  wire logic        group_start,
  input  wire logic        idle_mode,
  // Status
  output logic      [15:0] count_value,
  output logic             counting
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic                                enable;
  logic                                run;
  logic                                prescale_run;
  logic                                started;
  timer_capture_pkg::channel_config_s  cfg;
  logic [15:0]                         count;
  logic [15:0]                         compare_reg_1;
  logic [15:0]                         compare_buffer;
  logic [15:0]                         capture_reg_0;
  logic [15:0]                         capture_reg_1;
  logic [3:0]                          prescale;
  logic [2:0]                          in0_sync;
  logic [2:0]                          in1_sync;
  logic [2:0]                          match_sync;
  logic                                in0_state;
  logic                                in1_state;
  logic                                match_state;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire acc_ok    = enable;
  wire wr_enable = reg_write && reg_addr == timer_capture_pkg::ENABLE_OFFSET;
  wire wr_run    = reg_write && acc_ok && reg_addr == timer_capture_pkg::RUN_OFFSET;
  wire wr_ctrl   = reg_write && acc_ok && reg_addr == timer_capture_pkg::CONTROL_OFFSET;
  wire wr_mode   = reg_write && acc_ok && reg_addr == timer_capture_pkg::MODE_OFFSET;
  wire wr_rg1    = reg_write && acc_ok && reg_addr == timer_capture_pkg::RG1_OFFSET;
  wire soft_cap  = wr_mode && !reg_wdata[timer_capture_pkg::SOFTCAP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised edges: a change counts once stages two and three agree
  function automatic logic agreed(input logic [2:0] s, input logic old);
    agreed = (s[2] == s[1]) ? s[1] : old;
  endfunction

  wire in0_new   = agreed(in0_sync, in0_state);
  wire in1_new   = agreed(in1_sync, in1_state);
  wire match_new = agreed(match_sync, match_state);
  wire in0_rise  = in0_new && !in0_state;
  wire in0_fall  = !in0_new && in0_state;
  wire in1_rise  = in1_new && !in1_state;
  wire mt_rise   = match_new && !match_state;
  wire mt_fall   = !match_new && match_state;

  ////////////////////////////////////////////////////////////////////////////
  // Capture selection
  wire hw_cap0 = (cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_IN1  && in0_rise)
              || (cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_BOTH && in0_rise)
              || (cfg.capture_timing_select == timer_capture_pkg::CAP_MATCH_OUT && mt_rise);
  wire hw_cap1 = (cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_IN1  && in1_rise)
              || (cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_BOTH && in0_fall)
              || (cfg.capture_timing_select == timer_capture_pkg::CAP_MATCH_OUT && mt_fall);
  // CAP_OFF leaves both terms false
  wire cap0 = enable && (hw_cap0 || soft_cap);
  wire cap1 = enable && hw_cap1;

  ////////////////////////////////////////////////////////////////////////////
  // Count source and gating
  wire tap_pulse4  = (prescale & timer_capture_pkg::PRESCALE_4_MASK) == 4'h0;
  wire tap_pulse16 = (prescale & timer_capture_pkg::PRESCALE_16_MASK) == 4'h0;
  logic tick;
  always_comb
  begin
    unique case (cfg.count_clock_select)
      timer_capture_pkg::CLK_PIN:   tick = in0_rise;
      timer_capture_pkg::CLK_TAP1:  tick = prescale_run;
      timer_capture_pkg::CLK_TAP4:  tick = prescale_run && tap_pulse4;
      timer_capture_pkg::CLK_TAP16: tick = prescale_run && tap_pulse16;
    endcase
  end
  wire idle_ok    = !idle_mode || cfg.idle_run_enable;
  wire start_ok   = !cfg.sync_start_select || started;
  wire active     = enable && run && start_ok && idle_ok;
  wire at_match   = count == compare_reg_1;
  wire clear_now  = cfg.match_clear_enable && at_match;
  wire step       = active && tick;
  wire [15:0] next_count = clear_now ? timer_capture_pkg::COUNT_RESET : count + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Sequential logic
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      in0_sync    <= 3'h0;
      in1_sync    <= 3'h0;
      match_sync  <= 3'h0;
      in0_state   <= 1'b0;
      in1_state   <= 1'b0;
      match_state <= 1'b0;
    end
    else
    begin
      in0_sync    <= {in0_sync[1:0], capture_input_0};
      in1_sync    <= {in1_sync[1:0], capture_input_1};
      match_sync  <= {match_sync[1:0], group_leader_match_out};
      in0_state   <= in0_new;
      in1_state   <= in1_new;
      match_state <= match_new;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      enable       <= 1'b0;
      run          <= 1'b0;
      prescale_run <= 1'b0;
      cfg          <= '0;
    end
    else
    begin
      if (wr_enable)
        enable <= reg_wdata[timer_capture_pkg::ENABLE_BIT];
      if (wr_run)
      begin
        run          <= reg_wdata[timer_capture_pkg::RUN_BIT];
        prescale_run <= reg_wdata[timer_capture_pkg::PRESCALE_BIT];
      end
      if (wr_ctrl)
      begin
        cfg.double_buffer_enable <= reg_wdata[timer_capture_pkg::DBUF_BIT];
        cfg.sync_start_select    <= reg_wdata[timer_capture_pkg::SYNC_BIT];
        cfg.idle_run_enable      <= reg_wdata[timer_capture_pkg::IDLE_BIT];
      end
      if (wr_mode)
      begin
        cfg.capture_timing_select <= timer_capture_pkg::capture_mode_e'(
          reg_wdata[timer_capture_pkg::CAPSEL_LSB +: 2]);
        cfg.match_clear_enable    <= reg_wdata[timer_capture_pkg::CLEAR_BIT];
        cfg.count_clock_select    <= timer_capture_pkg::clock_select_e'(
          reg_wdata[timer_capture_pkg::CLKSEL_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      started <= 1'b0;
    else if (!run)
      started <= 1'b0;
    else if (group_start)
      started <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || !prescale_run)
      prescale <= 4'h0;
    else if (enable)
      prescale <= prescale + 4'h1;
  end

  // Stopping clears the counter; a disabled channel keeps its count
  always_ff @(posedge core_clk)
  begin
    if (reset)
      count <= timer_capture_pkg::COUNT_RESET;
    else if (enable && !run)
      count <= timer_capture_pkg::COUNT_RESET;
    else if (step)
      count <= next_count;
  end

  // Buffered writes land at the next match clear, so a period never tears
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      compare_reg_1  <= timer_capture_pkg::RG1_RESET;
      compare_buffer <= timer_capture_pkg::RG1_RESET;
    end
    else
    begin
      if (wr_rg1)
        compare_buffer <= reg_wdata[15:0];
      if (wr_rg1 && (!cfg.double_buffer_enable || !run))
        compare_reg_1 <= reg_wdata[15:0];
      else if (cfg.double_buffer_enable && step && clear_now)
        compare_reg_1 <= compare_buffer;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      capture_reg_0 <= 16'h0000;
      capture_reg_1 <= 16'h0000;
    end
    else
    begin
      if (cap0)
        capture_reg_0 <= count;
      if (cap1)
        capture_reg_1 <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back
  wire [31:0] ctrl_word = {24'h0, cfg.double_buffer_enable, 1'b0, cfg.sync_start_select,
                           1'b0, cfg.idle_run_enable, 3'h0} & timer_capture_pkg::CONTROL_READ_MASK;
  wire [31:0] mode_word = {26'h0, 1'b0, cfg.capture_timing_select, cfg.match_clear_enable,
                           cfg.count_clock_select} | timer_capture_pkg::SOFTCAP_READ_ONE;
  logic [31:0] read_mux;
  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (reg_addr == timer_capture_pkg::ENABLE_OFFSET)
      read_mux = {24'h0, enable, 7'h0};
    else if (acc_ok)
    begin
      unique case (reg_addr)
        timer_capture_pkg::RUN_OFFSET:     read_mux = {29'h0, prescale_run, 1'b0, run};
        timer_capture_pkg::CONTROL_OFFSET: read_mux = ctrl_word;
        timer_capture_pkg::MODE_OFFSET:    read_mux = mode_word;
        timer_capture_pkg::COUNT_OFFSET:   read_mux = {16'h0, count};
        timer_capture_pkg::RG1_OFFSET:     read_mux = {16'h0, compare_reg_1};
        timer_capture_pkg::CP0_OFFSET:     read_mux = {16'h0, capture_reg_0};
        timer_capture_pkg::CP1_OFFSET:     read_mux = {16'h0, capture_reg_1};
        default:                           read_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_read)
      reg_rdata <= read_mux;
    else
      reg_rdata <= 32'h0000_0000;
  end

  assign count_value = count;
  assign counting    = active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_soft_capture_load: assert property (@(posedge core_clk) disable iff (reset)
    soft_cap && enable |=> capture_reg_0 == $past(count))
    else $error("soft capture missed");
  a_capture_off_quiet: assert property (@(posedge core_clk) disable iff (reset)
    cfg.capture_timing_select == timer_capture_pkg::CAP_OFF && !soft_cap |=> $stable(capture_reg_0)
      && $stable(capture_reg_1))
    else $error("capture while disabled");
  a_in0_rise_cap: assert property (@(posedge core_clk) disable iff (reset)
    enable && in0_rise && (cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_IN1
      || cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_BOTH)
      |=> capture_reg_0 == $past(count))
    else $error("input 0 capture missed");
  a_in1_rise_cap: assert property (@(posedge core_clk) disable iff (reset)
    enable && cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_IN1 && in1_rise
      |=> capture_reg_1 == $past(count))
    else $error("input 1 capture missed");
  a_in0_fall_cap: assert property (@(posedge core_clk) disable iff (reset)
    enable && cfg.capture_timing_select == timer_capture_pkg::CAP_IN0_BOTH && in0_fall
      |=> capture_reg_1 == $past(count))
    else $error("falling capture missed");
  a_match_rise_cap: assert property (@(posedge core_clk) disable iff (reset)
    enable && cfg.capture_timing_select == timer_capture_pkg::CAP_MATCH_OUT && mt_rise
      |=> capture_reg_0 == $past(count))
    else $error("match capture missed");
  a_match_clear_zero: assert property (@(posedge core_clk) disable iff (reset)
    step && cfg.match_clear_enable && at_match |=> count == 16'h0000)
    else $error("match clear missed");
  a_no_clear_wrap: assert property (@(posedge core_clk) disable iff (reset)
    step && !cfg.match_clear_enable |=> count == $past(count) + 16'h0001)
    else $error("counter did not step");
  a_idle_halt: assert property (@(posedge core_clk) disable iff (reset)
    idle_mode && !cfg.idle_run_enable && run |=> $stable(count))
    else $error("counted in idle");
  a_sync_wait: assert property (@(posedge core_clk) disable iff (reset)
    cfg.sync_start_select && !started |-> !counting)
    else $error("started without group");
  a_disabled_hold: assert property (@(posedge core_clk) disable iff (reset)
    !enable && !wr_enable |=> $stable(cfg) && $stable(count))
    else $error("disabled channel changed");
  a_edge_once: assert property (@(posedge core_clk) disable iff (reset)
    in0_rise |=> !in0_rise)
    else $error("double edge event");
  // A buffered write may only reach the comparator at the clear that reloads it
  a_buffer_hold: assert property (@(posedge core_clk) disable iff (reset)
    wr_rg1 && cfg.double_buffer_enable && run && !(step && clear_now) |=> $stable(compare_reg_1))
    else $error("buffered write landed early");
  a_direct_write: assert property (@(posedge core_clk) disable iff (reset)
    wr_rg1 && !cfg.double_buffer_enable |=> compare_reg_1 == compare_buffer)
    else $error("direct write missed");
  a_pin_no_tick: assert property (@(posedge core_clk) disable iff (reset)
    enable && run && cfg.count_clock_select == timer_capture_pkg::CLK_PIN && !in0_rise
      |=> $stable(count))
    else $error("counted without pin edge");
  c_soft_capture: cover property (@(posedge core_clk) soft_cap && enable);
  c_match_clear:  cover property (@(posedge core_clk) step && clear_now);
  c_fall_capture: cover property (@(posedge core_clk) cap1 && in0_fall);
  c_sync_start:   cover property (@(posedge core_clk) cfg.sync_start_select && counting);
  c_buffer_load:  cover property (@(posedge core_clk) cfg.double_buffer_enable && step && clear_now);

endmodule // timer_capture_mode_control

// ### rtl/timer_capture_pkg.sv
// Package: register map, field positions, reset values and carriers for the timer channel
package timer_capture_pkg;

  localparam logic [7:0] ENABLE_OFFSET  = 8'h00;
  localparam logic [7:0] RUN_OFFSET     = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] MODE_OFFSET    = 8'h0C;
  localparam logic [7:0] RG1_OFFSET     = 8'h24;
  localparam logic [7:0] CP0_OFFSET     = 8'h28;
  localparam logic [7:0] CP1_OFFSET     = 8'h2C;
  localparam logic [7:0] COUNT_OFFSET   = 8'h1C;

  localparam int ENABLE_BIT     = 7;
  localparam int RUN_BIT        = 0;
  localparam int PRESCALE_BIT   = 2;
  localparam int DBUF_BIT       = 7;
  localparam int SYNC_BIT       = 5;
  localparam int IDLE_BIT       = 3;
  localparam int SOFTCAP_BIT    = 5;
  localparam int CAPSEL_LSB     = 3;
  localparam int CLEAR_BIT      = 2;
  localparam int CLKSEL_LSB     = 0;

  localparam logic [31:0] CONTROL_READ_MASK = 32'h0000_00EB;
  localparam logic [31:0] MODE_READ_MASK    = 32'h0000_005F;
  localparam logic [31:0] SOFTCAP_READ_ONE  = 32'h0000_0020;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
  localparam logic [15:0] RG1_RESET         = 16'h0000;

  localparam logic [3:0] PRESCALE_4_MASK  = 4'h3;
  localparam logic [3:0] PRESCALE_16_MASK = 4'hF;

  typedef enum logic [1:0]
  {
    CAP_OFF       = 2'b00,
    CAP_IN0_IN1   = 2'b01,
    CAP_IN0_BOTH  = 2'b10,
    CAP_MATCH_OUT = 2'b11
  } capture_mode_e;

  typedef enum logic [1:0]
  {
    CLK_PIN   = 2'b00,
    CLK_TAP1  = 2'b01,
    CLK_TAP4  = 2'b10,
    CLK_TAP16 = 2'b11
  } clock_select_e;

  typedef struct packed
  {
    logic          double_buffer_enable;
    logic          sync_start_select;
    logic          idle_run_enable;
    logic          match_clear_enable;
    capture_mode_e capture_timing_select;
    clock_select_e count_clock_select;
  } channel_config_s;

endpackage

// ### sim/capture_pin_model.sv
// Behavioural model of the capture pins and the group leader match output
`timescale 1ns/1ps

module capture_pin_model
(
  // Clock
  input  wire logic core_clk,
  // Levels asked for by the bench
  input  wire logic want_in0,
  input  wire logic want_in1,
  input  wire logic want_match,
  // Pins seen by the channel
  output logic      capture_input_0,
  output logic      capture_input_1,
  output logic      group_leader_match_out
);
  initial
  begin
    capture_input_0        = 1'b0;
    capture_input_1        = 1'b0;
    group_leader_match_out = 1'b0;
  end

  // Pins move off the clock grid, so the channel must synchronise them
  always @(posedge core_clk)
  begin
    #7;
    capture_input_0 = want_in0;
    capture_input_1 = want_in1;
    // The leader channel of the group owns the match line
    group_leader_match_out = want_match;
  end
endmodule // capture_pin_model

// ### sim/timer_capture_mode_control_bench.sv
// Self-checking bench for the timer channel mode and capture control
`timescale 1ns/1ps

module timer_capture_mode_control_bench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        capture_input_0;
  logic        capture_input_1;
  logic        group_leader_match_out;
  logic        group_start = 1'b0;
  logic        idle_mode = 1'b0;
  logic [15:0] count_value;
  logic        counting;
  logic        want_in0 = 1'b0;
  logic        want_in1 = 1'b0;
  logic        want_match = 1'b0;
  logic [15:0] base;
  logic [15:0] mx;
  logic [15:0] cnt;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  timer_capture_mode_control timer_capture_mode_control_i
  (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .capture_input_0(capture_input_0), .capture_input_1(capture_input_1),
    .group_leader_match_out(group_leader_match_out), .group_start(group_start),
    .idle_mode(idle_mode), .count_value(count_value), .counting(counting)
  );

  capture_pin_model capture_pin_model_i
  (
    .core_clk(core_clk), .want_in0(want_in0), .want_in1(want_in1), .want_match(want_match),
    .capture_input_0(capture_input_0), .capture_input_1(capture_input_1),
    .group_leader_match_out(group_leader_match_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    check(nm, reg_rdata, exp);
  endtask

  // Soft capture bit is kept at 1 so a mode write never captures by accident
  task automatic sm(input logic [1:0] cap, input logic clr, input logic [1:0] ck);
    wr(timer_capture_pkg::MODE_OFFSET, {26'h0, 1'b1, cap, clr, ck});
  endtask

  // Eight cycles cover the synchroniser delay plus the capture edge
  task automatic pin(input int sel, input logic lvl);
    @(posedge core_clk);
    if (sel == 0) want_in0 <= lvl;
    else if (sel == 1) want_in1 <= lvl;
    else want_match <= lvl;
    cyc(8);
  endtask

  // Count n pin edges, then freeze the counter on the stopped tap 16
  task automatic bump(input int n, input logic [1:0] cap);
    sm(2'b00, 1'b0, 2'b00);
    repeat (n)
    begin
      pin(0, 1'b1);
      pin(0, 1'b0);
    end
    cnt = cnt + 16'(n);
    sm(cap, 1'b0, 2'b11);
    check("count", {16'h0, count_value}, {16'h0, cnt});
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rc("mode_disabled", timer_capture_pkg::MODE_OFFSET, 32'h0);
    wr(timer_capture_pkg::ENABLE_OFFSET, 32'h80);
    rc("mode_reset", timer_capture_pkg::MODE_OFFSET, 32'h20);
    rc("ctrl_reset", timer_capture_pkg::CONTROL_OFFSET, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'hA8);
    rc("ctrl_bits", timer_capture_pkg::CONTROL_OFFSET, 32'hA8);
    // Sync start: the channel waits for the group pulse
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'h20);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h1);
    cyc(4);
    check("sync_wait", {31'h0, counting}, 32'h0);
    @(posedge core_clk);
    group_start <= 1'b1;
    @(posedge core_clk);
    group_start <= 1'b0;
    cyc(2);
    check("sync_go", {31'h0, counting}, 32'h1);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    // Idle: halt unless the idle bit keeps the channel going
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'h0);
    idle_mode <= 1'b1;
    wr(timer_capture_pkg::RUN_OFFSET, 32'h1);
    cyc(2);
    check("idle_halt", {31'h0, counting}, 32'h0);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'h08);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h1);
    cyc(2);
    check("idle_run", {31'h0, counting}, 32'h1);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'h0);
    idle_mode <= 1'b0;
    // Tap rates over a window that is a whole number of tap 16 periods
    wr(timer_capture_pkg::RUN_OFFSET, 32'h5);
    for (int k = 1; k < 4; k++)
    begin
      sm(2'b00, 1'b0, k[1:0]);
      cyc(4);
      base = count_value;
      cyc(32);
      check("rate", {16'h0, count_value - base}, 32'd32 >> (2 * (k - 1)));
    end
    // Match clear keeps the counter at or below compare register 1
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    wr(timer_capture_pkg::RG1_OFFSET, 32'h5);
    sm(2'b00, 1'b1, 2'b01);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h5);
    mx = 16'h0;
    repeat (40)
    begin
      cyc(1);
      if (count_value > mx) mx = count_value;
    end
    check("clear_max", {16'h0, mx}, 32'h5);
    sm(2'b00, 1'b0, 2'b01);
    cyc(20);
    check("no_clear", {31'h0, count_value > 16'h5}, 32'h1);
    // Buffered compare writes wait for the next match clear
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'h80);
    wr(timer_capture_pkg::RG1_OFFSET, 32'h2);
    sm(2'b00, 1'b1, 2'b00);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h1);
    wr(timer_capture_pkg::RG1_OFFSET, 32'h7);
    rc("buf_held", timer_capture_pkg::RG1_OFFSET, 32'h2);
    repeat (3)
    begin
      pin(0, 1'b1);
      pin(0, 1'b0);
    end
    rc("buf_loaded", timer_capture_pkg::RG1_OFFSET, 32'h7);
    check("buf_clear", {16'h0, count_value}, 32'h0);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    wr(timer_capture_pkg::CONTROL_OFFSET, 32'h0);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h1);
    wr(timer_capture_pkg::RG1_OFFSET, 32'h3);
    rc("direct_rg1", timer_capture_pkg::RG1_OFFSET, 32'h3);
    // Captures run with the prescaler stopped so the counter holds still
    wr(timer_capture_pkg::RUN_OFFSET, 32'h0);
    wr(timer_capture_pkg::RUN_OFFSET, 32'h1);
    cnt = 16'h0;
    bump(3, 2'b00);
    wr(timer_capture_pkg::MODE_OFFSET, 32'h03);
    rc("soft_cap", timer_capture_pkg::CP0_OFFSET, 32'h3);
    bump(2, 2'b00);
    rc("soft_one", timer_capture_pkg::CP0_OFFSET, 32'h3);
    for (int s = 0; s < 3; s++)
    begin
      pin(s, 1'b1);
      pin(s, 1'b0);
    end
    rc("off_cp0", timer_capture_pkg::CP0_OFFSET, 32'h3);
    rc("off_cp1", timer_capture_pkg::CP1_OFFSET, 32'h0);
    bump(1, 2'b01);
    pin(0, 1'b1);
    pin(0, 1'b0);
    rc("m1_cp0", timer_capture_pkg::CP0_OFFSET, 32'h6);
    rc("m1_cp1_kept", timer_capture_pkg::CP1_OFFSET, 32'h0);
    pin(1, 1'b1);
    rc("m1_cp1", timer_capture_pkg::CP1_OFFSET, 32'h6);
    pin(1, 1'b0);
    bump(1, 2'b10);
    pin(0, 1'b1);
    rc("m2_cp0", timer_capture_pkg::CP0_OFFSET, 32'h7);
    rc("m2_cp1_kept", timer_capture_pkg::CP1_OFFSET, 32'h6);
    pin(0, 1'b0);
    rc("m2_cp1", timer_capture_pkg::CP1_OFFSET, 32'h7);
    bump(1, 2'b11);
    pin(2, 1'b1);
    rc("m3_cp0", timer_capture_pkg::CP0_OFFSET, 32'h8);
    rc("m3_cp1_kept", timer_capture_pkg::CP1_OFFSET, 32'h7);
    pin(2, 1'b0);
    rc("m3_cp1", timer_capture_pkg::CP1_OFFSET, 32'h8);
    // Disabled channel ignores writes and keeps its settings
    wr(timer_capture_pkg::ENABLE_OFFSET, 32'h0);
    rc("off_read", timer_capture_pkg::MODE_OFFSET, 32'h0);
    wr(timer_capture_pkg::MODE_OFFSET, 32'h20);
    wr(timer_capture_pkg::ENABLE_OFFSET, 32'h80);
    rc("kept_mode", timer_capture_pkg::MODE_OFFSET, 32'h3B);
    report_and_stop();
  end
endmodule // timer_capture_mode_control_bench
